// ### design/csp_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1: Gate unused domain clocks per sleep mode
// RQ2: Async external interrupt wakes without I/O clock
// RQ3: Converter clock runs alone in noise reduction
// RQ4: PLL multiplies 8.0 MHz RC by eight
// RQ5: Low-speed select halves PLL source
// RQ6: Low-speed select refused when PLL drives system
// RQ7: Fast clock selectable for timer or system
// RQ8: Fuses 0011 trim RC 6.4, multiply 4x
// RQ9: No low-speed option in compatibility mode
// RQ10: Fast clock follows RC trim
// RQ11: Above 8 MHz saturate 85 MHz, lose lock
// RQ12: PLL on by enable bit or fuses
// RQ13: Lock flag set once PLL locked
// RQ14: RC and PLL off in deep sleep
// RQ15: Decode the four clock-source fuses
// RQ16: Fuse one means unprogrammed, zero programmed
// RQ17: Compatibility mode divides system clock by four
// RQ18: Wake from reset or deep sleep counts selected source cycles first
// RQ19: Reset adds none, 512 or 8K watchdog cycles
// RQ20: As-shipped fuses give RC, 10, divide-eight
// RQ21: Flash clock runs with core clock
// RQ22: Fuses sampled after reset release, then held
//////////////////////////////////////////////////////////////////////////////
package csp_pkg;

  // Clock-source fuse codes
  localparam logic [3:0] SRC_EXT   = 4'h0;
  localparam logic [3:0] SRC_PLL   = 4'h1;
  localparam logic [3:0] SRC_RC8   = 4'h2;
  localparam logic [3:0] SRC_RC64  = 4'h3;
  localparam logic [3:0] SRC_WDT   = 4'h4;
  localparam logic [3:0] SRC_RSV5  = 4'h5;
  localparam logic [3:0] SRC_LFX   = 4'h6;
  localparam logic [3:0] SRC_RSV7  = 4'h7;
  localparam int         XTAL_BIT  = 3;

  // Fuse reset values, as shipped
  localparam logic [3:0] FUSE_SRC_RST  = 4'h2;
  localparam logic [1:0] FUSE_SUT_RST  = 2'h2;
  localparam logic       FUSE_DIV8_RST = 1'b0;
  localparam logic       FUSE_PROG     = 1'b0;

  // Sleep mode codes
  localparam logic [1:0] SLP_IDLE  = 2'h0;
  localparam logic [1:0] SLP_ADCNR = 2'h1;
  localparam logic [1:0] SLP_PDOWN = 2'h2;
  localparam logic [1:0] SLP_STBY  = 2'h3;

  // Reset delay in watchdog oscillator cycles
  localparam logic [13:0] WDT_CYC_NONE = 14'h0000;
  localparam logic [13:0] WDT_CYC_4MS  = 14'h0200;
  localparam logic [13:0] WDT_CYC_64MS = 14'h2000;

  // Start-up delay in cycles of the selected source
  localparam logic [15:0] CK_6   = 16'h0006;
  localparam logic [15:0] CK_258 = 16'h0102;
  localparam logic [15:0] CK_1K  = 16'h0400;
  localparam logic [15:0] CK_16K = 16'h4000;
  localparam logic [15:0] CK_32K = 16'h8000;

  // PLL factors; frequencies in 100 kHz units
  localparam logic [3:0]  MULT_NORM   = 4'h8;
  localparam logic [3:0]  MULT_COMPAT = 4'h4;
  localparam logic [7:0]  RC_NOM_8M   = 8'h50;
  localparam logic [7:0]  RC_NOM_6M4  = 8'h40;
  localparam logic [7:0]  RC_LOCK_MAX = 8'h50;
  localparam logic [10:0] PCK_SAT     = 11'h352;

  // System clock prescale as log2 of the divider
  localparam logic [1:0] DIV_LOG2_1 = 2'h0;
  localparam logic [1:0] DIV_LOG2_4 = 2'h2;
  localparam logic [1:0] DIV_LOG2_8 = 2'h3;

  // PLL lock time
  localparam int          SYS_CLK_MHZ  = 20;
  localparam int          PLL_LOCK_US  = 100;
  localparam logic [11:0] PLL_LOCK_CYC = 12'(PLL_LOCK_US * SYS_CLK_MHZ);

  // Start-up and run sequencer states
  typedef enum logic [3:0] {
    ST_BOOT  = 4'h1,
    ST_RUN   = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE  = 4'h8
  } csp_state_t;

endpackage

// ### design/csp_clock_ctrl.sv
`timescale 1ns/1ns
module csp_clock_ctrl (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CLK_EN_I,
  input  wire logic [3:0]  CLOCK_SOURCE_FUSES_I,
  input  wire logic [1:0]  STARTUP_TIME_FUSES_I,
  input  wire logic        DIVIDE_BY_EIGHT_FUSE_I,
  input  wire logic        PLL_CTRL_WR_I,
  input  wire logic        PLL_ENABLE_BIT_I,
  input  wire logic        PLL_LOW_SPEED_SELECT_I,
  input  wire logic [7:0]  RC_FREQ_I,
  input  wire logic        TIMER_FAST_SEL_I,
  input  wire logic        SLEEP_REQ_I,
  input  wire logic [1:0]  SLEEP_MODE_I,
  input  wire logic        WAKE_I,
  input  wire logic        INT_IO_I,
  input  wire logic        EXT_INT_ASYNC_I,
  input  wire logic        WDT_TICK_I,
  input  wire logic        SRC_TICK_I,
  output logic             CORE_CLOCK_EN_O,
  output logic             IO_CLOCK_EN_O,
  output logic             FLASH_CLOCK_EN_O,
  output logic             CONVERTER_CLOCK_EN_O,
  output logic             RC_OSC_ON_O,
  output logic             PLL_ON_O,
  output logic             PLL_LOCK_FLAG_O,
  output logic             PLL_ENABLE_BIT_O,
  output logic             PLL_LOW_SPEED_SELECT_O,
  output logic             PLL_SRC_DIV2_O,
  output logic [3:0]       PLL_MULT_O,
  output logic [7:0]       RC_NOMINAL_O,
  output logic [10:0]      FAST_PCK_FREQ_O,
  output logic             PLL_SYSTEM_CLOCK_O,
  output logic             TIMER_FAST_CLOCK_O,
  output logic [3:0]       SYS_SOURCE_O,
  output logic             FUSE_RESERVED_O,
  output logic [1:0]       SYS_DIV_LOG2_O
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  csp_pkg::csp_state_t state_r, state_nxt;
  logic [3:0]  fuse_src_r,  fuse_src_nxt;
  logic [1:0]  fuse_sut_r,  fuse_sut_nxt;
  logic        fuse_div8_r, fuse_div8_nxt;
  logic        fuses_ok_r,  fuses_ok_nxt;
  logic [1:0]  slp_mode_r,  slp_mode_nxt;
  logic [13:0] wdt_cnt_r,   wdt_cnt_nxt;
  logic [15:0] ck_cnt_r,    ck_cnt_nxt;
  logic [11:0] lock_cnt_r,  lock_cnt_nxt;
  logic        pll_en_r,    pll_en_nxt;
  logic        lsm_r,       lsm_nxt;
  logic [10:0] pck_nxt;
  logic [11:0] prod;
  logic [7:0]  pll_src;
  logic [13:0] wdt_goal;
  logic [15:0] ck_goal;
  logic        compat, pll_sys, reserved, deep, osc_off, pll_req, wake_any;
  logic        lock_nxt, core_nxt, io_nxt, adc_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Fuse decode, fuse bits taken raw: zero is programmed
  always_comb begin
    compat   = (fuse_src_r == csp_pkg::SRC_RC64);                     // see RQ8
    pll_sys  = (fuse_src_r == csp_pkg::SRC_PLL);                      // see RQ15
    reserved = (fuse_src_r == csp_pkg::SRC_RSV5) ||
               (fuse_src_r == csp_pkg::SRC_RSV7);                     // see RQ15
    deep     = (slp_mode_r == csp_pkg::SLP_PDOWN) || (slp_mode_r == csp_pkg::SLP_STBY);
  end

  // Reset delay goal in watchdog cycles
  always_comb begin
    case (fuse_sut_r)
      2'h0:    wdt_goal = csp_pkg::WDT_CYC_NONE;
      2'h1:    wdt_goal = csp_pkg::WDT_CYC_4MS;                        // see RQ19
      default: wdt_goal = csp_pkg::WDT_CYC_64MS;                       // see RQ19
    endcase
  end

  // Start-up goal in cycles of the selected source
  always_comb begin
    ck_goal = csp_pkg::CK_6;                                           // see RQ18
    if (fuse_src_r[csp_pkg::XTAL_BIT]) begin
      if (!fuse_src_r[0] && !fuse_sut_r[1]) begin
        ck_goal = csp_pkg::CK_258;
      end else if (!fuse_src_r[0] || fuse_sut_r == 2'h0) begin
        ck_goal = csp_pkg::CK_1K;
      end else begin
        ck_goal = csp_pkg::CK_16K;
      end
    end else if (fuse_src_r == csp_pkg::SRC_LFX) begin
      ck_goal = fuse_sut_r[1] ? csp_pkg::CK_32K : csp_pkg::CK_1K;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fuse capture after reset release, then frozen
  always_comb begin
    fuses_ok_nxt  = 1'b1;
    fuse_src_nxt  = fuse_src_r;
    fuse_sut_nxt  = fuse_sut_r;
    fuse_div8_nxt = fuse_div8_r;
    if (!fuses_ok_r) begin
      fuse_src_nxt  = CLOCK_SOURCE_FUSES_I;                            // see RQ22
      fuse_sut_nxt  = STARTUP_TIME_FUSES_I;
      fuse_div8_nxt = DIVIDE_BY_EIGHT_FUSE_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: reset delay, run, sleep, wake delay
  always_comb begin
    state_nxt    = state_r;
    slp_mode_nxt = slp_mode_r;
    wdt_cnt_nxt  = wdt_cnt_r;
    ck_cnt_nxt   = ck_cnt_r;
    wake_any     = WAKE_I || EXT_INT_ASYNC_I ||                        // see RQ2
                   (slp_mode_r == csp_pkg::SLP_IDLE && INT_IO_I);
    case (state_r)
      csp_pkg::ST_BOOT: begin
        ck_cnt_nxt = '0;
        if (fuses_ok_r) begin
          if (wdt_cnt_r >= wdt_goal) begin
            state_nxt = csp_pkg::ST_WAKE;                              // see RQ19
          end else if (WDT_TICK_I) begin
            wdt_cnt_nxt = wdt_cnt_r + 14'h0001;
          end
        end
      end
      csp_pkg::ST_RUN: begin
        if (SLEEP_REQ_I) begin
          state_nxt    = csp_pkg::ST_SLEEP;
          slp_mode_nxt = SLEEP_MODE_I;
        end
      end
      csp_pkg::ST_SLEEP: begin
        ck_cnt_nxt = '0;
        if (wake_any) begin
          state_nxt = deep ? csp_pkg::ST_WAKE : csp_pkg::ST_RUN;       // see RQ18
        end
      end
      csp_pkg::ST_WAKE: begin
        if (ck_cnt_r >= ck_goal) begin
          state_nxt = csp_pkg::ST_RUN;                                 // see RQ18
        end else if (SRC_TICK_I) begin
          ck_cnt_nxt = ck_cnt_r + 16'h0001;
        end
      end
      default: state_nxt = csp_pkg::ST_BOOT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Domain clock enables follow the next state
  always_comb begin
    core_nxt = (state_nxt == csp_pkg::ST_RUN);                         // see RQ1
    io_nxt   = core_nxt ||
               (state_nxt == csp_pkg::ST_SLEEP && slp_mode_nxt == csp_pkg::SLP_IDLE);
    adc_nxt  = io_nxt ||
               (state_nxt == csp_pkg::ST_SLEEP && slp_mode_nxt == csp_pkg::SLP_ADCNR); // see RQ3
    osc_off  = (state_nxt == csp_pkg::ST_SLEEP) &&
               (slp_mode_nxt == csp_pkg::SLP_PDOWN || slp_mode_nxt == csp_pkg::SLP_STBY); // see RQ14
  end

  //////////////////////////////////////////////////////////////////////////////
  // PLL control bits and lock tracking
  always_comb begin
    pll_en_nxt   = pll_en_r;
    lsm_nxt      = lsm_r;
    lock_cnt_nxt = lock_cnt_r;
    if (PLL_CTRL_WR_I) begin
      pll_en_nxt = PLL_ENABLE_BIT_I;
      lsm_nxt    = PLL_LOW_SPEED_SELECT_I && !pll_sys;                 // see RQ6
    end
    if (compat || pll_sys) begin
      lsm_nxt = 1'b0;                                                  // see RQ6 see RQ9
    end
    pll_req = (pll_en_nxt || pll_sys || compat) && !osc_off;           // see RQ12
    if (!pll_req || RC_FREQ_I > csp_pkg::RC_LOCK_MAX) begin
      lock_cnt_nxt = '0;                                               // see RQ11
    end else if (lock_cnt_r != csp_pkg::PLL_LOCK_CYC) begin
      lock_cnt_nxt = lock_cnt_r + 12'h001;
    end
    lock_nxt = (lock_cnt_nxt == csp_pkg::PLL_LOCK_CYC);                // see RQ13
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fast peripheral clock frequency model
  always_comb begin
    pll_src = lsm_nxt ? {1'b0, RC_FREQ_I[7:1]} : RC_FREQ_I;           // see RQ5
    prod    = compat ? {2'h0, pll_src, 2'h0} : {1'b0, pll_src, 3'h0}; // see RQ4
    pck_nxt = '0;
    if (pll_req) begin
      pck_nxt = (prod > {1'b0, csp_pkg::PCK_SAT}) ? csp_pkg::PCK_SAT : prod[10:0]; // see RQ10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register all state
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r     <= csp_pkg::ST_BOOT;
      fuse_src_r  <= csp_pkg::FUSE_SRC_RST;                            // see RQ20
      fuse_sut_r  <= csp_pkg::FUSE_SUT_RST;
      fuse_div8_r <= csp_pkg::FUSE_DIV8_RST;
      fuses_ok_r  <= 1'b0;
      slp_mode_r  <= csp_pkg::SLP_IDLE;
      wdt_cnt_r   <= '0;
      ck_cnt_r    <= '0;
      lock_cnt_r  <= '0;
      pll_en_r    <= 1'b0;
      lsm_r       <= 1'b0;
    end else if (CLK_EN_I) begin
      state_r     <= state_nxt;
      fuse_src_r  <= fuse_src_nxt;
      fuse_sut_r  <= fuse_sut_nxt;
      fuse_div8_r <= fuse_div8_nxt;
      fuses_ok_r  <= fuses_ok_nxt;
      slp_mode_r  <= slp_mode_nxt;
      wdt_cnt_r   <= wdt_cnt_nxt;
      ck_cnt_r    <= ck_cnt_nxt;
      lock_cnt_r  <= lock_cnt_nxt;
      pll_en_r    <= pll_en_nxt;
      lsm_r       <= lsm_nxt;
    end
  end

  // Register all outputs
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CORE_CLOCK_EN_O        <= 1'b0;
      IO_CLOCK_EN_O          <= 1'b0;
      FLASH_CLOCK_EN_O       <= 1'b0;
      CONVERTER_CLOCK_EN_O   <= 1'b0;
      RC_OSC_ON_O            <= 1'b1;
      PLL_ON_O               <= 1'b0;
      PLL_LOCK_FLAG_O        <= 1'b0;
      PLL_ENABLE_BIT_O       <= 1'b0;
      PLL_LOW_SPEED_SELECT_O <= 1'b0;
      PLL_SRC_DIV2_O         <= 1'b0;
      PLL_MULT_O             <= csp_pkg::MULT_NORM;
      RC_NOMINAL_O           <= csp_pkg::RC_NOM_8M;
      FAST_PCK_FREQ_O        <= '0;
      PLL_SYSTEM_CLOCK_O     <= 1'b0;
      TIMER_FAST_CLOCK_O     <= 1'b0;
      SYS_SOURCE_O           <= csp_pkg::FUSE_SRC_RST;
      FUSE_RESERVED_O        <= 1'b0;
      SYS_DIV_LOG2_O         <= csp_pkg::DIV_LOG2_8;
    end else if (CLK_EN_I) begin
      CORE_CLOCK_EN_O        <= core_nxt;                              // see RQ1
      IO_CLOCK_EN_O          <= io_nxt;
      FLASH_CLOCK_EN_O       <= core_nxt;                              // see RQ21
      CONVERTER_CLOCK_EN_O   <= adc_nxt;                               // see RQ3
      RC_OSC_ON_O            <= !osc_off;                              // see RQ14
      PLL_ON_O               <= pll_req;                               // see RQ12
      PLL_LOCK_FLAG_O        <= lock_nxt;                              // see RQ13
      PLL_ENABLE_BIT_O       <= pll_en_nxt;
      PLL_LOW_SPEED_SELECT_O <= lsm_nxt;
      PLL_SRC_DIV2_O         <= lsm_nxt;                               // see RQ5
      PLL_MULT_O             <= compat ? csp_pkg::MULT_COMPAT : csp_pkg::MULT_NORM; // see RQ8
      RC_NOMINAL_O           <= compat ? csp_pkg::RC_NOM_6M4 : csp_pkg::RC_NOM_8M;  // see RQ8
      FAST_PCK_FREQ_O        <= pck_nxt;
      PLL_SYSTEM_CLOCK_O     <= pll_sys;                               // see RQ7
      TIMER_FAST_CLOCK_O     <= TIMER_FAST_SEL_I && pll_req;           // see RQ7
      SYS_SOURCE_O           <= reserved ? csp_pkg::SRC_RC8 : fuse_src_r; // see RQ15
      FUSE_RESERVED_O        <= reserved;
      if (compat) begin
        SYS_DIV_LOG2_O <= csp_pkg::DIV_LOG2_4;                         // see RQ17
      end else if (fuse_div8_r == csp_pkg::FUSE_PROG) begin
        SYS_DIV_LOG2_O <= csp_pkg::DIV_LOG2_8;                         // see RQ16
      end else begin
        SYS_DIV_LOG2_O <= csp_pkg::DIV_LOG2_1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_core_only_run: assert property (CORE_CLOCK_EN_O == (state_r == csp_pkg::ST_RUN)) // see RQ1
    else $error("core clock enable disagrees with run state");
  a_flash_with_core: assert property (FLASH_CLOCK_EN_O == CORE_CLOCK_EN_O) // see RQ21
    else $error("flash clock differs from core clock");
  a_adc_noise_red: assert property ((state_r == csp_pkg::ST_SLEEP && slp_mode_r == csp_pkg::SLP_ADCNR) // see RQ3
    |-> CONVERTER_CLOCK_EN_O && !IO_CLOCK_EN_O && !CORE_CLOCK_EN_O)
    else $error("converter domain wrong in noise reduction");
  a_async_int_wake: assert property ((CLK_EN_I && state_r == csp_pkg::ST_SLEEP && EXT_INT_ASYNC_I) // see RQ2
    |=> state_r != csp_pkg::ST_SLEEP)
    else $error("async interrupt did not leave sleep");
  a_lsm_refused: assert property ((pll_sys || compat) && $past(fuses_ok_r) // see RQ6
    |-> !PLL_LOW_SPEED_SELECT_O)
    else $error("low-speed select set while refused");
  a_compat_setup: assert property ((compat && $past(fuses_ok_r)) // see RQ8
    |-> PLL_MULT_O == csp_pkg::MULT_COMPAT && RC_NOMINAL_O == csp_pkg::RC_NOM_6M4 &&
        SYS_DIV_LOG2_O == csp_pkg::DIV_LOG2_4)
    else $error("compatibility mode settings wrong");
  a_pck_saturate: assert property (FAST_PCK_FREQ_O <= csp_pkg::PCK_SAT) // see RQ11
    else $error("fast clock above saturation");
  a_lock_needs_pll: assert property ($rose(PLL_LOCK_FLAG_O) |-> PLL_ON_O && // see RQ13
    $past(lock_cnt_r) == csp_pkg::PLL_LOCK_CYC - 12'h001)
    else $error("lock flag rose without full lock time");
  a_deep_osc_off: assert property ((state_r == csp_pkg::ST_SLEEP && deep) // see RQ14
    |-> !RC_OSC_ON_O && !PLL_ON_O && !PLL_LOCK_FLAG_O)
    else $error("oscillators running in deep sleep");
  a_fuses_frozen: assert property (fuses_ok_r |=> $stable(fuse_src_r) && $stable(fuse_div8_r)) // see RQ22
    else $error("fuse values changed during operation");

  // Fuse-selected PLL, source and fast clock settings
  a_pll_fuse_on: assert property (((pll_sys || compat) && $past(fuses_ok_r) && $past(CLK_EN_I)) // see RQ12
    && RC_OSC_ON_O |-> PLL_ON_O)
    else $error("pll off although fuses enable it");
  a_reserved_src: assert property ((reserved && $past(fuses_ok_r) && $past(CLK_EN_I)) // see RQ15
    |-> SYS_SOURCE_O == csp_pkg::SRC_RC8 && FUSE_RESERVED_O)
    else $error("reserved source code not replaced");
  a_pck_times_eight: assert property ((PLL_ON_O && !PLL_LOW_SPEED_SELECT_O && !compat && // see RQ10
    $past(CLK_EN_I) && $past(fuses_ok_r) && $stable(RC_FREQ_I) && RC_FREQ_I <= csp_pkg::RC_LOCK_MAX)
    |-> FAST_PCK_FREQ_O == {RC_FREQ_I, 3'h0})
    else $error("fast clock not eight times the trim");
  a_timer_needs_pll: assert property (TIMER_FAST_CLOCK_O |-> PLL_ON_O) // see RQ7
    else $error("timer on fast clock while pll off");

  // Lock loss and start-up delays
  a_lock_drops: assert property ((CLK_EN_I && RC_FREQ_I > csp_pkg::RC_LOCK_MAX) // see RQ11
    |=> !PLL_LOCK_FLAG_O)
    else $error("lock flag kept with trim above range");
  a_boot_delay: assert property ((state_r == csp_pkg::ST_WAKE && $past(state_r) == csp_pkg::ST_BOOT) // see RQ19
    |-> $past(wdt_cnt_r) >= $past(wdt_goal))
    else $error("reset delay cut short");
  a_wake_counted: assert property ((state_r == csp_pkg::ST_RUN && $past(state_r) == csp_pkg::ST_WAKE) // see RQ18
    |-> $past(ck_cnt_r) >= $past(ck_goal))
    else $error("wake delay cut short");

  c_adc_sleep: cover property (state_r == csp_pkg::ST_SLEEP && slp_mode_r == csp_pkg::SLP_ADCNR);
  c_lock_rise: cover property ($rose(PLL_LOCK_FLAG_O));
  c_deep_wake: cover property (state_r == csp_pkg::ST_WAKE && $past(state_r) == csp_pkg::ST_SLEEP);
  c_saturate:  cover property (FAST_PCK_FREQ_O == csp_pkg::PCK_SAT);
  c_compat_run: cover property (state_r == csp_pkg::ST_RUN && compat);

endmodule

// ### tb/csp_testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        sys_clk, rst_n, wr, en_i, low_spd, tsel, slp_req, wake, int_io, ext_int, tick, div8, ce;
  logic [3:0]  src_fuse, mult, src;
  logic [1:0]  st_fuse, slp_mode, dlog;
  logic [7:0]  rc, rc_nom;
  logic        core_en, io_en, fl_en, cv_en, rc_on, pll_on, lock, en_o, low_o, div2_o, pll_sys, tfast, rsv;
  logic [10:0] pck;
  int          err_total, checks, seed, cy, m;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and source/watchdog tick train, one pulse every other cycle
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tick <= (tick !== 1'b1);

  csp_clock_ctrl dut_u (
    .SYS_CLK_I(sys_clk), .RST_N_I(rst_n), .CLK_EN_I(ce), .CLOCK_SOURCE_FUSES_I(src_fuse),
    .STARTUP_TIME_FUSES_I(st_fuse), .DIVIDE_BY_EIGHT_FUSE_I(div8), .PLL_CTRL_WR_I(wr),
    .PLL_ENABLE_BIT_I(en_i), .PLL_LOW_SPEED_SELECT_I(low_spd), .RC_FREQ_I(rc), .TIMER_FAST_SEL_I(tsel),
    .SLEEP_REQ_I(slp_req), .SLEEP_MODE_I(slp_mode), .WAKE_I(wake), .INT_IO_I(int_io),
    .EXT_INT_ASYNC_I(ext_int), .WDT_TICK_I(tick), .SRC_TICK_I(tick), .CORE_CLOCK_EN_O(core_en),
    .IO_CLOCK_EN_O(io_en), .FLASH_CLOCK_EN_O(fl_en), .CONVERTER_CLOCK_EN_O(cv_en), .RC_OSC_ON_O(rc_on),
    .PLL_ON_O(pll_on), .PLL_LOCK_FLAG_O(lock), .PLL_ENABLE_BIT_O(en_o), .PLL_LOW_SPEED_SELECT_O(low_o),
    .PLL_SRC_DIV2_O(div2_o), .PLL_MULT_O(mult), .RC_NOMINAL_O(rc_nom), .FAST_PCK_FREQ_O(pck),
    .PLL_SYSTEM_CLOCK_O(pll_sys), .TIMER_FAST_CLOCK_O(tfast), .SYS_SOURCE_O(src),
    .FUSE_RESERVED_O(rsv), .SYS_DIV_LOG2_O(dlog)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [10:0] pck_exp(input logic [7:0] r, input logic on, input logic ls,
                                          input logic [3:0] f);
    int v;
    if (!on) return 11'h000;
    v = r * ((f == 4'h3) ? 4 : 8);
    if (ls) v = v / 2;
    return (v > 32'h352) ? 11'h352 : 11'(v);
  endfunction

  function automatic int goal(input logic [3:0] f, input logic [1:0] s);
    if (f[3]) return (!f[0] && !s[1]) ? 258 : ((!f[0] || s == 2'h0) ? 1024 : 16384);
    if (f == 4'h6) return s[1] ? 32768 : 1024;
    return 6;
  endfunction

  function automatic int rdelay(input logic [1:0] s);
    return (s == 2'h0) ? 0 : ((s == 2'h1) ? 512 : 8192);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bounded waits
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_run(output int c);
    c = 0;
    while (core_en !== 1'b1) begin
      @(negedge sys_clk);
      c++;
      if (c > 40000) begin
        chk(16'h0, 16'h1, "run wait timeout");
        finish_test();
      end
    end
  endtask

  // Reset with given fuses, check reset values, release and wait for run
  task automatic boot(input logic [3:0] f, input logic [1:0] s, input logic d);
    @(posedge sys_clk);
    rst_n    <= 1'b0;
    src_fuse <= f;
    st_fuse  <= s;
    div8     <= d;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({core_en, io_en, fl_en, cv_en, rc_on, pll_on, lock}, 16'h04, "reset enables");
    chk({mult, rc_nom, src}, 16'h8502, "reset mult nominal source");
    chk(dlog, 2'h3, "reset prescale");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wait_run(cy);
    chk(cy >= 2 * (rdelay(s) + goal(f, s)) && cy <= 2 * (rdelay(s) + goal(f, s)) + 30, 1'b1,
        "start-up length");
  endtask

  task automatic fuse_chk(input logic [3:0] f, input logic d);
    chk(src, (f == 4'h5 || f == 4'h7) ? 4'h2 : f, "decoded source");
    chk(rsv, f == 4'h5 || f == 4'h7, "reserved flag");
    chk(dlog, (f == 4'h3) ? 2'h2 : (d ? 2'h0 : 2'h3), "prescale");
    chk({mult, rc_nom}, (f == 4'h3) ? 12'h440 : 12'h850, "mult and nominal");
    chk(pll_sys, f == 4'h1, "pll as system");
    chk(pll_on, f == 4'h1 || f == 4'h3, "pll on by fuses");
    chk(pck, pck_exp(rc, f == 4'h1 || f == 4'h3, 1'b0, f), "fast clock freq");
    chk(fl_en, core_en, "flash with core");
  endtask

  task automatic pll_write(input logic e, input logic l);
    @(posedge sys_clk);
    wr      <= 1'b1;
    en_i    <= e;
    low_spd <= l;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, wr, en_i, low_spd, tsel, slp_req, wake, int_io, ext_int, div8, ce} = 11'h001;
    {src_fuse, st_fuse, slp_mode, rc} = 16'h2050;
    err_total = 0;
    checks    = 0;
    seed      = 32'h099B;
    // As-shipped fuses, then the short reset time-out
    boot(4'h2, 2'h2, 1'b0);
    fuse_chk(4'h2, 1'b0);
    boot(4'h2, 2'h1, 1'b1);
    fuse_chk(4'h2, 1'b1);
    // Every source code, random trim and divide fuse
    for (int f = 0; f < 16; f++) begin
      @(posedge sys_clk);
      rc <= (f == 3) ? 8'h40 : (8'($random(seed)) & 8'h4E);
      boot(4'(f), 2'h0, 1'($random(seed)));
      fuse_chk(4'(f), div8);
      @(posedge sys_clk);
      src_fuse <= ~4'(f);
      pll_write(1'b1, 1'b1);
      repeat (2) @(negedge sys_clk);
      chk(src, (f == 5 || f == 7) ? 4'h2 : 4'(f), "fuses held");
      chk(low_o, !(f == 1 || f == 3), "low speed refusal");
      chk(pck, pck_exp(rc, 1'b1, !(f == 1 || f == 3), 4'(f)), "fast clock after write");
    end
    // PLL enable, lock, low speed and saturation
    @(posedge sys_clk);
    rc <= 8'h50;
    boot(4'h2, 2'h0, 1'b1);
    pll_write(1'b1, 1'b0);
    chk({en_o, pll_on, pck}, 13'h1A80, "pll on at 64 MHz");
    for (cy = 1; lock !== 1'b1 && cy < 3000; cy++) @(negedge sys_clk);
    chk(cy >= 1990 && cy <= 2010, 1'b1, "lock time");
    @(posedge sys_clk);
    tsel <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(tfast, 1'b1, "timer fast clock");
    pll_write(1'b1, 1'b1);
    chk({low_o, div2_o, pck}, 13'h1940, "low speed 32 MHz");
    @(posedge sys_clk);
    rc <= 8'hFF;
    repeat (3) @(negedge sys_clk);
    chk({lock, pck}, 12'h352, "saturation and unlock");
    @(posedge sys_clk);
    rc <= 8'h50;
    pll_write(1'b0, 1'b0);
    chk({pll_on, tfast, pck}, 13'h0, "pll off");
    // Clock enable low freezes a PLL write
    @(posedge sys_clk);
    ce <= 1'b0;
    pll_write(1'b1, 1'b0);
    chk({en_o, pll_on}, 2'h0, "write ignored while frozen");
    @(posedge sys_clk);
    ce <= 1'b1;
    // Each sleep mode, its clock gating and its wake source
    for (m = 0; m < 4; m++) begin
      pll_write(1'b1, 1'b0);
      @(posedge sys_clk);
      slp_req  <= 1'b1;
      slp_mode <= 2'(m);
      @(posedge sys_clk);
      slp_req <= 1'b0;
      @(negedge sys_clk);
      chk({core_en, fl_en, io_en, cv_en}, {2'b00, m == 0, m < 2}, "sleep gating");
      chk({rc_on, pll_on}, (m < 2) ? 2'h3 : 2'h0, "deep sleep oscillators");
      if (m > 0) begin
        @(posedge sys_clk);
        int_io <= 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(core_en, 1'b0, "clocked interrupt ignored");
      end
      @(posedge sys_clk);
      int_io  <= (m == 0);
      wake    <= (m == 1);
      ext_int <= (m > 1);
      wait_run(cy);
      chk(cy <= 40, 1'b1, "wake length");
      chk({fl_en, io_en, cv_en, rc_on}, 4'hF, "clocks back after wake");
      @(posedge sys_clk);
      {int_io, wake, ext_int} <= 3'h0;
    end
    finish_test();
  end
endmodule
